// ===== design/tpa_pkg.sv
// Package of constants, types and the register map for the tariff period accumulator
`default_nettype none
package tpa_pkg;
   localparam int NUM_CAL   = 20;
   localparam int NUM_SCHED = 16;
   localparam int SLOT_MIN  = 15;
   localparam int SLOTS     = 24 * 60 / SLOT_MIN;
   localparam int NUM_TAR   = 8;
   localparam int NUM_SEA   = 4;
   localparam int NUM_MON   = 12;
   localparam int DAYS      = 366;

   // Byte offsets of the word registers
   localparam logic [9:0] OFS_CTRL   = 10'h000;
   localparam logic [9:0] OFS_STATUS = 10'h004;
   localparam logic [9:0] OFS_VALID  = 10'h008;
   localparam logic [9:0] OFS_SEL    = 10'h00c;
   localparam logic [9:0] OFS_DST    = 10'h010;
   localparam logic [9:0] OFS_TADDR  = 10'h014;
   localparam logic [9:0] OFS_TDATA  = 10'h018;
   localparam logic [1:0] TOT_PAGE   = 2'h1;

   // Field positions
   localparam int CTRL_CLR     = 0;
   localparam int CTRL_DSTUSR  = 1;
   localparam int CTRL_ROLLING = 2;
   localparam int DST_END_LSB  = 16;
   localparam int TA_SEL_LSB   = 28;
   localparam int TA_IDX_LSB   = 16;

   // Table selects for indirect writes
   localparam logic [1:0] TBL_DAYMAP = 2'h0;
   localparam logic [1:0] TBL_SCHED  = 2'h1;
   localparam logic [1:0] TBL_SEASON = 2'h2;
   localparam logic [1:0] TBL_BILL   = 2'h3;

   // Reset values
   localparam logic [19:0] RST_VALID = 20'h00001;
   localparam logic [4:0]  RST_SEL   = 5'h00;
   localparam logic [8:0]  RST_DSTS  = 9'h000;
   localparam logic [8:0]  RST_DSTE  = 9'h000;

   // Daylight saving bounds for the automatic mode
   localparam logic [3:0] DST_MON_START = 4'h3;
   localparam logic [3:0] DST_MON_END   = 4'hb;
   localparam logic [5:0] DST_SUN2_MIN  = 6'h08;

   typedef enum logic [1:0] {
      TPA_RUN  = 2'b00,
      TPA_HALT = 2'b01
   } tpa_state_e;

   // Present time from the meter time base, same clock domain
   typedef struct packed {
      logic [8:0] doy;   // Day of year, 0 based
      logic [3:0] month; // 1 to 12
      logic [4:0] day;   // 1 to 31
      logic [2:0] wday;  // 0 is Sunday
      logic [6:0] slot;  // Fifteen-minute slot 0 to 95
   } tpa_time_s;
endpackage
`default_nettype wire

// ===== design/tpa_top.sv
// Tariff period accumulator with Avalon-MM register slave
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`default_nettype none
module tpa_top (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              ce,
   input  wire logic [9:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   input  wire tpa_pkg::tpa_time_s time_now,
   input  wire logic              day_tick,
   input  wire logic              year_tick,
   input  wire logic              energy_inc,
   input  wire logic [15:0]       energy_val,
   output logic                   dst_active,
   output logic                   demand_rolling,
   output logic                   halted,
   output logic [4:0]             active_cal
);
   ////////////////////////////////////////////////////////////////////////////
   logic [31:0]           readdata_q;
   logic                  waitrequest_q;
   logic                  wr_fire;
   logic                  clr_cmd;
   logic                  sel_cmd;
   logic                  dst_user_q;
   logic                  rolling_q;
   logic [19:0]           valid_q;
   logic [4:0]            sel_q;
   logic [8:0]            dsts_q;
   logic [8:0]            dste_q;
   logic [31:0]           taddr_q;
   logic [31:0]           rd_mux;
   logic [31:0]           tdata_rd;

   logic [3:0]            day_map_q [tpa_pkg::NUM_CAL][tpa_pkg::DAYS];
   logic [2:0]            sched_q   [tpa_pkg::NUM_SCHED][tpa_pkg::SLOTS];
   logic [8:0]            sea_st_q  [tpa_pkg::NUM_CAL][tpa_pkg::NUM_SEA];
   logic [4:0]            bill_q    [tpa_pkg::NUM_CAL][tpa_pkg::NUM_MON];

   logic [31:0]           cur_sea_q [tpa_pkg::NUM_TAR];
   logic [31:0]           cur_mon_q [tpa_pkg::NUM_TAR];
   logic [31:0]           pri_sea_q [tpa_pkg::NUM_TAR];
   logic [31:0]           pri_mon_q [tpa_pkg::NUM_TAR];

   tpa_pkg::tpa_state_e   state_q;
   logic [4:0]            cal_q;
   logic [4:0]            next_cal;
   logic                  running;
   logic                  sea_close;
   logic                  mon_close;
   logic                  year_end;
   logic                  sea_rst_q;
   logic                  mon_rst_q;
   logic [8:0]            sea_end_q;
   logic [3:0]            mon_end_m_q;
   logic [4:0]            mon_end_d_q;
   logic [1:0]            season_q;
   logic [2:0]            tar_sel;
   logic [3:0]            sched_sel;
   logic [1:0]            ns_idx;
   logic [8:0]            ns_start;
   logic [3:0]            me_m;
   logic [4:0]            me_d;
   logic                  dst_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: every access answers one cycle after it is seen on a cycle with ce high; while ce is low it waits
   assign wr_fire = avs_write && !waitrequest_q;
   assign clr_cmd = wr_fire && avs_address == tpa_pkg::OFS_CTRL
                    && avs_writedata[tpa_pkg::CTRL_CLR];
   assign sel_cmd = wr_fire && avs_address == tpa_pkg::OFS_SEL;

   always_ff @(posedge mclk) begin
      if (reset) begin
         waitrequest_q <= 1'b1;
         readdata_q    <= 32'h0;
      end else if (ce) begin
         if (waitrequest_q && (avs_read || avs_write)) begin
            waitrequest_q <= 1'b0;
            readdata_q    <= avs_read ? rd_mux : 32'h0;
         end else begin
            waitrequest_q <= 1'b1;
         end
      end
   end

   assign avs_readdata    = readdata_q;
   assign avs_waitrequest = waitrequest_q;

   always_comb begin
      tdata_rd = 32'h0;
      unique case (taddr_q[tpa_pkg::TA_SEL_LSB +: 2])
         tpa_pkg::TBL_DAYMAP:
            tdata_rd[3:0] = day_map_q[taddr_q[tpa_pkg::TA_IDX_LSB +: 5]][taddr_q[8:0]];
         tpa_pkg::TBL_SCHED:
            tdata_rd[2:0] = sched_q[taddr_q[tpa_pkg::TA_IDX_LSB +: 4]][taddr_q[6:0]];
         tpa_pkg::TBL_SEASON:
            tdata_rd[8:0] = sea_st_q[taddr_q[tpa_pkg::TA_IDX_LSB +: 5]][taddr_q[1:0]];
         tpa_pkg::TBL_BILL:
            tdata_rd[4:0] = bill_q[taddr_q[tpa_pkg::TA_IDX_LSB +: 5]][taddr_q[3:0]];
      endcase
   end

   always_comb begin
      rd_mux = 32'h0;
      if (avs_address[9:8] == tpa_pkg::TOT_PAGE) begin
         unique case (avs_address[6:5])
            2'h0: rd_mux = cur_sea_q[avs_address[4:2]];
            2'h1: rd_mux = cur_mon_q[avs_address[4:2]];
            2'h2: rd_mux = pri_sea_q[avs_address[4:2]];
            2'h3: rd_mux = pri_mon_q[avs_address[4:2]];
         endcase
      end else begin
         unique case (avs_address)
            tpa_pkg::OFS_CTRL:   rd_mux = {29'h0, rolling_q, dst_user_q, 1'b0};
            tpa_pkg::OFS_STATUS: rd_mux = {5'h0, mon_end_d_q, mon_end_m_q, sea_end_q,
                                           season_q, dst_q, !running, cal_q};
            tpa_pkg::OFS_VALID:  rd_mux = {12'h0, valid_q};
            tpa_pkg::OFS_SEL:    rd_mux = {27'h0, sel_q};
            tpa_pkg::OFS_DST:    rd_mux = {7'h0, dste_q, 7'h0, dsts_q};
            tpa_pkg::OFS_TADDR:  rd_mux = taddr_q;
            tpa_pkg::OFS_TDATA:  rd_mux = tdata_rd;
            default:             rd_mux = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         dst_user_q <= 1'b0;
         rolling_q  <= 1'b0;
         valid_q    <= tpa_pkg::RST_VALID;
         sel_q      <= tpa_pkg::RST_SEL;
         dsts_q     <= tpa_pkg::RST_DSTS;
         dste_q     <= tpa_pkg::RST_DSTE;
         taddr_q    <= 32'h0;
      end else if (ce && wr_fire) begin
         unique case (avs_address)
            tpa_pkg::OFS_CTRL: begin
               dst_user_q <= avs_writedata[tpa_pkg::CTRL_DSTUSR];
               rolling_q  <= avs_writedata[tpa_pkg::CTRL_ROLLING];
            end
            tpa_pkg::OFS_VALID: valid_q <= avs_writedata[19:0];
            tpa_pkg::OFS_SEL:   sel_q   <= avs_writedata[4:0];
            tpa_pkg::OFS_DST: begin
               dsts_q <= avs_writedata[8:0];
               dste_q <= avs_writedata[tpa_pkg::DST_END_LSB +: 9];
            end
            tpa_pkg::OFS_TADDR: taddr_q <= avs_writedata;
            default: ;
         endcase
      end
   end

   // Calendar tables: separate from the accumulator so loading never stalls it
   always_ff @(posedge mclk) begin
      if (ce && wr_fire && avs_address == tpa_pkg::OFS_TDATA) begin
         unique case (taddr_q[tpa_pkg::TA_SEL_LSB +: 2])
            tpa_pkg::TBL_DAYMAP:
               day_map_q[taddr_q[tpa_pkg::TA_IDX_LSB +: 5]][taddr_q[8:0]] <= avs_writedata[3:0];
            tpa_pkg::TBL_SCHED:
               sched_q[taddr_q[tpa_pkg::TA_IDX_LSB +: 4]][taddr_q[6:0]] <= avs_writedata[2:0];
            tpa_pkg::TBL_SEASON:
               sea_st_q[taddr_q[tpa_pkg::TA_IDX_LSB +: 5]][taddr_q[1:0]] <= avs_writedata[8:0];
            tpa_pkg::TBL_BILL:
               bill_q[taddr_q[tpa_pkg::TA_IDX_LSB +: 5]][taddr_q[3:0]] <= avs_writedata[4:0];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slot lookup and period end detection
   assign sched_sel = day_map_q[cal_q][time_now.doy];
   assign tar_sel   = sched_q[sched_sel][time_now.slot];
   assign running   = state_q == tpa_pkg::TPA_RUN;
   assign next_cal  = (cal_q == 5'(tpa_pkg::NUM_CAL - 1)) ? 5'h0 : cal_q + 5'h1;
   assign year_end  = running && day_tick && year_tick;
   // A new start day closes the old season at the midnight just passed
   assign sea_close = running && day_tick && time_now.doy == sea_end_q;
   assign mon_close = running && day_tick && time_now.month == mon_end_m_q
                      && time_now.day == mon_end_d_q;

   // Next season start after today, wrapping into the following year
   always_comb begin
      logic found;
      logic [1:0] lo_idx;
      found  = 1'b0;
      lo_idx = 2'h0;
      ns_idx = 2'h0;
      for (int i = 0; i < tpa_pkg::NUM_SEA; i++) begin
         if (sea_st_q[cal_q][i] < sea_st_q[cal_q][lo_idx])
            lo_idx = 2'(i);
         if (sea_st_q[cal_q][i] > time_now.doy &&
             (!found || sea_st_q[cal_q][i] < sea_st_q[cal_q][ns_idx])) begin
            ns_idx = 2'(i);
            found  = 1'b1;
         end
      end
      if (!found)
         ns_idx = lo_idx;
      ns_start = sea_st_q[cal_q][ns_idx];
   end

   // Billing date still ahead this month, else next month's
   always_comb begin
      logic [3:0] m2;
      m2   = (time_now.month == 4'(tpa_pkg::NUM_MON)) ? 4'h1 : time_now.month + 4'h1;
      me_m = time_now.month;
      me_d = bill_q[cal_q][4'(time_now.month - 4'h1)];
      if (time_now.day >= me_d) begin
         me_m = m2;
         me_d = bill_q[cal_q][4'(m2 - 4'h1)];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Run state and active calendar
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= tpa_pkg::TPA_RUN;
         cal_q   <= tpa_pkg::RST_SEL;
      end else if (ce) begin
         if (sel_cmd) begin
            cal_q   <= avs_writedata[4:0];
            state_q <= tpa_pkg::TPA_RUN;
         end else if (year_end) begin
            if (valid_q[next_cal])
               cal_q <= next_cal;
            else
               state_q <= tpa_pkg::TPA_HALT;
         end
      end
   end

   // End dates are latched so a replaced calendar only takes effect afterwards
   always_ff @(posedge mclk) begin
      if (reset) begin
         sea_rst_q <= 1'b1;
         mon_rst_q <= 1'b1;
      end else if (ce) begin
         sea_rst_q <= sea_close || clr_cmd || sel_cmd;
         mon_rst_q <= mon_close || clr_cmd || sel_cmd;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         sea_end_q <= 9'h0;
         season_q  <= 2'h0;
      end else if (ce && sea_rst_q) begin
         sea_end_q <= ns_start;
         season_q  <= ns_idx - 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         mon_end_m_q <= 4'h0;
         mon_end_d_q <= 5'h0;
      end else if (ce && mon_rst_q) begin
         mon_end_m_q <= me_m;
         mon_end_d_q <= me_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-tariff totals; energy arriving on a close lands in the new period
   for (genvar t = 0; t < tpa_pkg::NUM_TAR; t++) begin : g_tar
      logic add_here;
      assign add_here = running && energy_inc && tar_sel == 3'(t);

      always_ff @(posedge mclk) begin
         if (reset) begin
            cur_sea_q[t] <= 32'h0;
         end else if (ce) begin
            if (sea_close || clr_cmd)
               cur_sea_q[t] <= add_here ? 32'(energy_val) : 32'h0;
            else if (add_here)
               cur_sea_q[t] <= cur_sea_q[t] + 32'(energy_val);
         end
      end

      always_ff @(posedge mclk) begin
         if (reset) begin
            cur_mon_q[t] <= 32'h0;
         end else if (ce) begin
            if (mon_close || clr_cmd)
               cur_mon_q[t] <= add_here ? 32'(energy_val) : 32'h0;
            else if (add_here)
               cur_mon_q[t] <= cur_mon_q[t] + 32'(energy_val);
         end
      end

      // No reset path reaches the prior totals
      always_ff @(posedge mclk) begin
         if (ce && sea_close)
            pri_sea_q[t] <= cur_sea_q[t];
         if (ce && mon_close)
            pri_mon_q[t] <= cur_mon_q[t];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Daylight saving and demand method; automatic mode ignores the 02:00 hour
   always_ff @(posedge mclk) begin
      if (reset) begin
         dst_q <= 1'b0;
      end else if (ce) begin
         if (dst_user_q)
            dst_q <= time_now.doy >= dsts_q && time_now.doy <= dste_q;
         else if (time_now.month > tpa_pkg::DST_MON_START &&
                  time_now.month < tpa_pkg::DST_MON_END)
            dst_q <= 1'b1;
         else if (time_now.month == tpa_pkg::DST_MON_START)
            dst_q <= {1'b0, time_now.day} >= {3'h0, time_now.wday} + tpa_pkg::DST_SUN2_MIN;
         else if (time_now.month == tpa_pkg::DST_MON_END)
            dst_q <= time_now.day <= {2'h0, time_now.wday};
         else
            dst_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         halted         <= 1'b0;
         active_cal     <= tpa_pkg::RST_SEL;
         demand_rolling <= 1'b0;
         dst_active     <= 1'b0;
      end else if (ce) begin
         halted         <= state_q == tpa_pkg::TPA_HALT;
         active_cal     <= cal_q;
         demand_rolling <= rolling_q;
         dst_active     <= dst_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic halted_next;
   assign halted_next = state_q == tpa_pkg::TPA_HALT;

   AST_BUS_ONE: assert property (@(posedge mclk) disable iff (reset)
      ce && avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");
   AST_ACC: assert property (@(posedge mclk) disable iff (reset)
      ce && running && energy_inc && !sea_close && !clr_cmd
      |=> cur_sea_q[$past(tar_sel)] == $past(cur_sea_q[tar_sel]) + 32'($past(energy_val)))
      else $error("season total did not accumulate energy");
   AST_SEA_PRI: assert property (@(posedge mclk) disable iff (reset)
      ce && sea_close |=> pri_sea_q[0] == $past(cur_sea_q[0]))
      else $error("season total not moved to prior");
   AST_SEA_CLR: assert property (@(posedge mclk) disable iff (reset)
      ce && sea_close && !energy_inc |=> cur_sea_q[1] == 32'h0)
      else $error("season total not cleared at close");
   AST_MON_PRI: assert property (@(posedge mclk) disable iff (reset)
      ce && mon_close ##1 ce |=> pri_mon_q[2] == $past(cur_mon_q[2], 2))
      else $error("month total not moved to prior");
   AST_HALT: assert property (@(posedge mclk) disable iff (reset)
      ce && year_end && !sel_cmd && !valid_q[next_cal] |=> halted_next)
      else $error("no halt at year end without calendar");
   AST_SWITCH: assert property (@(posedge mclk) disable iff (reset)
      ce && year_end && !sel_cmd && valid_q[next_cal] |=> cal_q == $past(next_cal) && running)
      else $error("calendar not switched at year end");
   AST_PRI_KEEP: assert property (@(posedge mclk) disable iff (reset)
      ce && clr_cmd && !mon_close |=> $stable(pri_mon_q[0]))
      else $error("prior total changed by reset command");
   AST_RESTART: assert property (@(posedge mclk) disable iff (reset)
      ce && clr_cmd ##1 ce |=> sea_end_q == $past(ns_start))
      else $error("end date not relatched after reset command");
   AST_DEMAND: assert property (@(posedge mclk) disable iff (reset)
      ce && wr_fire && avs_address == tpa_pkg::OFS_CTRL ##1 ce
      |=> demand_rolling == $past(avs_writedata[tpa_pkg::CTRL_ROLLING], 2))
      else $error("demand method output wrong");

   COV_SEA: cover property (@(posedge mclk) disable iff (reset) ce && sea_close);
   COV_MON: cover property (@(posedge mclk) disable iff (reset) ce && mon_close);
   COV_HALT: cover property (@(posedge mclk) disable iff (reset) halted_next);
   COV_SW: cover property (@(posedge mclk) disable iff (reset) ce && year_end && valid_q[next_cal]);
endmodule
`default_nettype wire

// ===== tb/tpa_host.sv
// Host side model: Avalon-MM master for register accesses
`default_nettype none
module tpa_host (
   input  wire logic        mclk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output logic [9:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   // Request stays put until waitrequest is seen low; only the bench watchdog ends a dead wait
   task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge mclk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== tb/tariff_period_accumulator_tb_top.sv
// Self-checking bench for the tariff period accumulator
`default_nettype none
module tariff_period_accumulator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [6:0] slot; logic [15:0] val; logic [2:0] tar;} tpa_row_s;
   logic               mclk, reset, ce, day_tick, year_tick, energy_inc;
   logic [15:0]        energy_val;
   tpa_pkg::tpa_time_s time_now;
   logic               avs_read, avs_write, avs_waitrequest;
   logic [9:0]         avs_address;
   logic [31:0]        avs_writedata, avs_readdata, q, k;
   logic               dst_active, demand_rolling, halted;
   logic [4:0]         active_cal;
   logic [31:0]        exp_t [8];
   int                 failures, compares;
   tpa_row_s           rows [4] = '{'{7'h03, 16'h0100, 3'h3}, '{7'h0b, 16'h0007, 3'h3},
                                    '{7'h05, 16'h0020, 3'h5}, '{7'h00, 16'hffff, 3'h0}};
   tpa_top u_dut (.mclk, .reset, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .time_now, .day_tick, .year_tick, .energy_inc,
      .energy_val, .dst_active, .demand_rolling, .halted, .active_cal);
   tpa_host u_host (.mclk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
      .avs_write, .avs_writedata);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] ta(input logic [1:0] s, input logic [8:0] e);
      return {2'h0, s, 19'h0, e};
   endfunction
   function automatic logic [9:0] tot(input logic [1:0] kd, input int t);
      return {3'h2, kd, 3'(t), 2'h0};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      u_host.acc(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] e);
      u_host.acc(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   task automatic tbl(input logic [1:0] s, input int e, input int d);
      wr(tpa_pkg::OFS_TADDR, ta(s, 9'(e)));
      wr(tpa_pkg::OFS_TDATA, 32'(d));
   endtask
   task automatic pulse(input logic [6:0] s, input logic [15:0] v);
      @(posedge mclk);
      time_now.slot <= s;
      energy_inc <= 1'b1;
      energy_val <= v;
      @(posedge mclk);
      energy_inc <= 1'b0;
   endtask
   task automatic tick(input logic [8:0] d, input logic [3:0] m, input logic [4:0] dd,
                       input logic y);
      @(posedge mclk);
      time_now.doy <= d;
      time_now.month <= m;
      time_now.day <= dd;
      day_tick <= 1'b1;
      year_tick <= y;
      @(posedge mclk);
      day_tick <= 1'b0;
      year_tick <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic test_done();
      $display("Counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      test_done();
   end
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      day_tick = 1'b0;
      year_tick = 1'b0;
      energy_inc = 1'b0;
      energy_val = 16'h0;
      time_now = '{9'h00a, 4'h1, 5'h0b, 3'h0, 7'h00};
      repeat (16) @(posedge mclk);
      chk("waitrequest", 32'h1, {31'h0, avs_waitrequest});
      reset <= 1'b0;
      $display("Test reset done");
      for (int i = 0; i < 96; i++) begin
         tbl(2'h0, i, 0);
         if (i < 16) tbl(2'h1, i, i % 8);
         if (i < 12) tbl(2'h3, i, 1);
         if (i < 4) tbl(2'h2, i, i * 90);
      end
      wr(tpa_pkg::OFS_TADDR, ta(2'h2, 9'h003));
      rdc("table", tpa_pkg::OFS_TDATA, 32'h10e);
      wr(tpa_pkg::OFS_SEL, 32'h0);
      foreach (exp_t[t]) exp_t[t] = 32'h0;
      foreach (rows[r]) begin
         pulse(rows[r].slot, rows[r].val);
         exp_t[rows[r].tar] += 32'(rows[r].val);
      end
      foreach (exp_t[t]) begin
         rdc("cur season", tot(2'h0, t), exp_t[t]);
         rdc("cur month", tot(2'h1, t), exp_t[t]);
      end
      $display("Test slots done");
      tick(9'h01f, 4'h2, 5'h01, 1'b0);
      rdc("season kept", tot(2'h0, 3), exp_t[3]);
      tick(9'h05a, 4'h4, 5'h01, 1'b0);
      foreach (exp_t[t]) begin
         rdc("prior month", tot(2'h3, t), exp_t[t]);
         rdc("prior season", tot(2'h2, t), exp_t[t]);
         rdc("cur month", tot(2'h1, t), 32'h0);
         rdc("cur season", tot(2'h0, t), 32'h0);
      end
      $display("Test close done");
      pulse(7'h03, 16'h0005);
      pulse(7'h03, 16'h0009);
      rdc("cur season", tot(2'h0, 3), 32'he);
      wr(tpa_pkg::OFS_CTRL, 32'h1);
      rdc("cleared", tot(2'h0, 3), 32'h0);
      rdc("prior kept", tot(2'h2, 3), exp_t[3]);
      @(posedge mclk);
      ce <= 1'b0;
      pulse(7'h03, 16'h0005);
      @(posedge mclk);
      ce <= 1'b1;
      rdc("frozen", tot(2'h0, 3), 32'h0);
      wr(tpa_pkg::OFS_CTRL, 32'h4);
      repeat (3) @(posedge mclk);
      chk("demand_rolling", 32'h1, {31'h0, demand_rolling});
      chk("dst_active", 32'h1, {31'h0, dst_active});
      rdc("ctrl", tpa_pkg::OFS_CTRL, 32'h4);
      rdc("status", tpa_pkg::OFS_STATUS, 32'h0055_68c0);
      wr(tpa_pkg::OFS_DST, 32'h0064_0050);
      wr(tpa_pkg::OFS_CTRL, 32'h6);
      repeat (3) @(posedge mclk);
      chk("dst user", 32'h1, {31'h0, dst_active});
      rdc("dst", tpa_pkg::OFS_DST, 32'h0064_0050);
      rdc("unmapped", 10'h0fc, 32'h0);
      $display("Test clear and modes done");
      wr(tpa_pkg::OFS_VALID, 32'h3);
      tick(9'h000, 4'h1, 5'h01, 1'b1);
      chk("active_cal", 32'h1, {27'h0, active_cal});
      chk("halted", 32'h0, {31'h0, halted});
      tick(9'h000, 4'h1, 5'h01, 1'b1);
      chk("halted", 32'h1, {31'h0, halted});
      u_host.acc(1'b0, tot(2'h0, 0), 32'h0, k);
      pulse(7'h00, 16'h0010);
      rdc("halted total", tot(2'h0, 0), k);
      wr(tpa_pkg::OFS_SEL, 32'h0);
      repeat (3) @(posedge mclk);
      chk("resumed", 32'h0, {26'h0, active_cal, halted});
      $display("Test year end done");
      test_done();
   end
endmodule
`default_nettype wire
